/* verilog/isc_defs.vh */
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define ISC_NSRC 32
`define ISC_AW 9
`define ISC_DW 32
`define ISC_NEXT 4

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ISC_OFF_MODE_LAST 9'h07C
`define ISC_OFF_VECTOR 9'h100
`define ISC_OFF_FVECTOR 9'h104
`define ISC_OFF_PENDING 9'h108
`define ISC_OFF_MASK 9'h110
`define ISC_OFF_ENCMD 9'h120
`define ISC_OFF_DISCMD 9'h124
`define ISC_OFF_CLRCMD 9'h128
`define ISC_OFF_SETCMD 9'h12C
`define ISC_OFF_FFORCE 9'h140
`define ISC_OFF_EVSTS 9'h150
`define ISC_OFF_EVMSK 9'h154
`define ISC_OFF_REQSTS 9'h158

// ----------------------------------------------------------------------
// trigger type field: bit1 edge, bit0 inverted polarity on external sources only
// ----------------------------------------------------------------------
`define ISC_TT_HIGH 2'h0
`define ISC_TT_LOW 2'h1
`define ISC_TT_RISE 2'h2
`define ISC_TT_FALL 2'h3
`define ISC_TT_EDGE_BIT 1
`define ISC_TT_INV_BIT 0

// ----------------------------------------------------------------------
// source map and reset values
// ----------------------------------------------------------------------
`define ISC_EXT_MASK 32'hE000_0001
`define ISC_FIRST_EXT_HI 29
`define ISC_MODE_RST 2'h0
`define ISC_MASK_RST 32'h0000_0000
`define ISC_FFORCE_RST 32'h0000_0000
`define ISC_FFORCE_WMASK 32'hFFFF_FFFE
`define ISC_NORMAL_MASK 32'hFFFF_FFFE
`define ISC_SPURIOUS 32'h0000_0020
`define ISC_FAST_VEC 32'h0000_0000

// ----------------------------------------------------------------------
// event status bits
// ----------------------------------------------------------------------
`define ISC_EV_REQ 0
`define ISC_EV_SPUR 1
`define ISC_EV_W 2
`define ISC_EV_RST 2'h0

`endif

/* verilog/isc_sync.v */
`timescale 1ns/1ps
`include "isc_defs.vh"

// two-stage synchroniser for the external interrupt pins
module isc_sync (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // asynchronous pins in, synchronised levels out
   input wire [`ISC_NEXT-1:0] pin_in,
   output reg [`ISC_NEXT-1:0] pin_sync
);

   reg [`ISC_NEXT-1:0] meta_q;

   // first stage feeds only the second stage
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= {`ISC_NEXT{1'b0}};
         pin_sync <= {`ISC_NEXT{1'b0}};
      end else begin
         meta_q <= pin_in;
         pin_sync <= meta_q;
      end
   end

endmodule

/* verilog/isc_source.v */
`timescale 1ns/1ps
`include "isc_defs.vh"

// one interrupt source: trigger qualification and edge memory
module isc_source (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // source line and its configuration
   input wire src_raw,
   input wire is_ext,
   input wire [1:0] trig,
   // software and vector-read commands
   input wire set_cmd,
   input wire clr_cmd,
   input wire auto_clr,
   // qualified activity
   output wire active
);

   reg lvl_q;
   reg latch_q;
   reg latch_d;
   wire inv;
   wire edge_mode;
   wire lvl;
   wire edge_det;

   assign inv = is_ext & trig[`ISC_TT_INV_BIT];
   assign lvl = src_raw ^ inv;
   assign edge_mode = trig[`ISC_TT_EDGE_BIT];
   assign edge_det = lvl & ~lvl_q;

   // edge memory, set has priority over any clear
   always @* begin
      latch_d = latch_q;
      if (!edge_mode) begin
         latch_d = 1'b0;
      end else if (edge_det | set_cmd) begin
         latch_d = 1'b1;
      end else if (clr_cmd | auto_clr) begin
         latch_d = 1'b0;
      end
   end

   // previous level and latch storage
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lvl_q <= 1'b0;
         latch_q <= 1'b0;
      end else begin
         lvl_q <= lvl;
         latch_q <= latch_d;
      end
   end

   assign active = edge_mode ? latch_q : lvl;

endmodule

/* verilog/isc_top.v */
`timescale 1ns/1ps
`include "isc_defs.vh"

module isc_top (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // register port
   input wire [`ISC_AW-1:0] addr,
   input wire [`ISC_DW-1:0] wdata,
   input wire wr,
   input wire rd,
   output reg [`ISC_DW-1:0] rdata_q,
   // interrupt lines from peripherals (same clock)
   input wire [28:1] periph_irq,
   // external interrupt pins: bit0 fast, bits 1-3 sources 29-31
   input wire [`ISC_NEXT-1:0] ext_irq_pin,
   // requests to the processor core
   output reg irq_core_q,
   output reg fiq_core_q,
   // block event interrupt
   output reg int_q
);

   // -------------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------------

   // true when the address selects a source mode register
   function is_mode_addr;
      input [`ISC_AW-1:0] a;
      begin
         is_mode_addr = (a <= `ISC_OFF_MODE_LAST) && (a[1:0] == 2'b00);
      end
   endfunction

   // lowest set bit index; bit5 high when none is set
   function [5:0] first_idx;
      input [`ISC_NSRC-1:0] v;
      integer k;
      begin
         first_idx = 6'h20;
         for (k = `ISC_NSRC - 1; k >= 0; k = k - 1) begin
            if (v[k]) begin
               first_idx = k[5:0];
            end
         end
      end
   endfunction

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   reg [1:0] mode_q [0:`ISC_NSRC-1];
   reg [`ISC_NSRC-1:0] mask_q;
   reg [`ISC_NSRC-1:0] mask_d;
   reg [`ISC_NSRC-1:0] fforce_q;
   reg [`ISC_EV_W-1:0] evsts_q;
   reg [`ISC_EV_W-1:0] evsts_d;
   reg [`ISC_EV_W-1:0] evmsk_q;
   reg [`ISC_DW-1:0] rdata_d;
   reg [`ISC_NSRC-1:0] auto_clr;

   wire [`ISC_NEXT-1:0] ext_sync;
   wire [`ISC_NSRC-1:0] pend;
   wire [`ISC_NSRC-1:0] set_cmd;
   wire [`ISC_NSRC-1:0] clr_cmd;
   wire [`ISC_NSRC-1:0] live;
   wire [`ISC_NSRC-1:0] normal_cand;
   wire [5:0] cur;
   wire cur_none;
   wire irq_core_d;
   wire fiq_core_d;
   wire vec_rd;
   wire fvec_rd;
   wire mode_wr;
   wire [4:0] mode_idx;
   wire [`ISC_EV_W-1:0] ev_new;
   wire [`ISC_EV_W-1:0] ev_clr;
   integer i;

   // -------------------------------------------------------------------
   // access strobes
   // -------------------------------------------------------------------

   // decoded strobes for side-effect registers
   assign vec_rd = rd && (addr == `ISC_OFF_VECTOR);
   assign fvec_rd = rd && (addr == `ISC_OFF_FVECTOR);
   assign mode_wr = wr && is_mode_addr(addr);
   assign mode_idx = addr[6:2];

   assign set_cmd = (wr && (addr == `ISC_OFF_SETCMD)) ? wdata :
                    {`ISC_NSRC{1'b0}};
   assign clr_cmd = (wr && (addr == `ISC_OFF_CLRCMD)) ? wdata :
                    {`ISC_NSRC{1'b0}};

   // -------------------------------------------------------------------
   // pin synchroniser
   // -------------------------------------------------------------------

   isc_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin_in(ext_irq_pin),
      .pin_sync(ext_sync)
   );

   // -------------------------------------------------------------------
   // source cells
   // -------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `ISC_NSRC; g = g + 1) begin : g_src
         wire raw;
         if (g == 0) begin : g_fast
            assign raw = ext_sync[0];
         end else if (g >= `ISC_FIRST_EXT_HI) begin : g_ext
            assign raw = ext_sync[g - `ISC_FIRST_EXT_HI + 1];
         end else begin : g_int
            assign raw = periph_irq[g];
         end
         isc_source u_src (
            .clk(clk),
            .rst_b(rst_b),
            .src_raw(raw),
            .is_ext(live[g]),
            .trig(mode_q[g]),
            .set_cmd(set_cmd[g]),
            .clr_cmd(clr_cmd[g]),
            .auto_clr(auto_clr[g]),
            .active(pend[g])
         );
      end
   endgenerate

   // external flag per source
   assign live = `ISC_EXT_MASK;

   // -------------------------------------------------------------------
   // current interrupt selection
   // -------------------------------------------------------------------

   assign normal_cand = pend & mask_q & ~fforce_q & `ISC_NORMAL_MASK;
   assign cur = first_idx(normal_cand);
   assign cur_none = cur[5];

   // auto clear pulses on vector reads
   always @* begin
      auto_clr = {`ISC_NSRC{1'b0}};
      if (vec_rd && !cur_none) begin
         auto_clr[cur[4:0]] = ~fforce_q[cur[4:0]];
      end
      if (fvec_rd) begin
         auto_clr[0] = 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // core requests
   // -------------------------------------------------------------------

   assign irq_core_d = |normal_cand;
   // fast-forced sources join the fast line
   assign fiq_core_d = |(pend & mask_q & (fforce_q |
                         ~`ISC_NORMAL_MASK));

   // -------------------------------------------------------------------
   // enable mask
   // -------------------------------------------------------------------

   // set and clear of the mask by command writes
   always @* begin
      mask_d = mask_q;
      if (wr && (addr == `ISC_OFF_ENCMD)) begin
         mask_d = mask_q | wdata;
      end
      if (wr && (addr == `ISC_OFF_DISCMD)) begin
         mask_d = mask_q & ~wdata;
      end
   end

   // -------------------------------------------------------------------
   // block events
   // -------------------------------------------------------------------

   // new request edge and spurious vector read
   assign ev_new[`ISC_EV_REQ] = (irq_core_d & ~irq_core_q) |
                                (fiq_core_d & ~fiq_core_q);
   assign ev_new[`ISC_EV_SPUR] = vec_rd & cur_none;
   assign ev_clr = (wr && (addr == `ISC_OFF_EVSTS)) ?
                   wdata[`ISC_EV_W-1:0] : {`ISC_EV_W{1'b0}};

   // sticky status, an event wins over a clear
   always @* begin
      evsts_d = (evsts_q & ~ev_clr) | ev_new;
   end

   // -------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------

   // read data selection, unmapped reads give zero
   always @* begin
      rdata_d = {`ISC_DW{1'b0}};
      if (is_mode_addr(addr)) begin
         rdata_d[1:0] = mode_q[mode_idx];
      end else begin
         case (addr)
            `ISC_OFF_VECTOR: begin
               rdata_d = cur_none ? `ISC_SPURIOUS : {26'h000_0000, cur};
            end
            `ISC_OFF_FVECTOR: begin
               rdata_d = `ISC_FAST_VEC;
            end
            `ISC_OFF_PENDING: begin
               rdata_d = pend;
            end
            `ISC_OFF_MASK: begin
               rdata_d = mask_q;
            end
            `ISC_OFF_FFORCE: begin
               rdata_d = fforce_q;
            end
            `ISC_OFF_EVSTS: begin
               rdata_d[`ISC_EV_W-1:0] = evsts_q;
            end
            `ISC_OFF_EVMSK: begin
               rdata_d[`ISC_EV_W-1:0] = evmsk_q;
            end
            `ISC_OFF_REQSTS: begin
               rdata_d[1:0] = {fiq_core_q, irq_core_q};
            end
            default: begin
               rdata_d = {`ISC_DW{1'b0}};
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------

   // mode storage, one entry per source
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < `ISC_NSRC; i = i + 1) begin
            mode_q[i] <= `ISC_MODE_RST;
         end
      end else if (mode_wr) begin
         mode_q[mode_idx] <= wdata[1:0];
      end
   end

   // mask, fast forcing and event registers
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= `ISC_MASK_RST;
         fforce_q <= `ISC_FFORCE_RST;
         evsts_q <= `ISC_EV_RST;
         evmsk_q <= `ISC_EV_RST;
      end else begin
         mask_q <= mask_d;
         evsts_q <= evsts_d;
         if (wr && (addr == `ISC_OFF_FFORCE)) begin
            fforce_q <= wdata & `ISC_FFORCE_WMASK;
         end
         if (wr && (addr == `ISC_OFF_EVMSK)) begin
            evmsk_q <= wdata[`ISC_EV_W-1:0];
         end
      end
   end

   // registered outputs
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= {`ISC_DW{1'b0}};
         irq_core_q <= 1'b0;
         fiq_core_q <= 1'b0;
         int_q <= 1'b0;
      end else begin
         rdata_q <= rd ? rdata_d : {`ISC_DW{1'b0}};
         irq_core_q <= irq_core_d;
         fiq_core_q <= fiq_core_d;
         int_q <= |(evsts_d & evmsk_q);
      end
   end

endmodule

/* tb/isc_properties.sv */
`timescale 1ns/1ps
`include "isc_defs.vh"

// ----------------------------------------
// port-level checks of the source control
// ----------------------------------------
module isc_properties (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // register port
   input wire [`ISC_AW-1:0] addr,
   input wire [`ISC_DW-1:0] wdata,
   input wire wr,
   input wire rd,
   input wire [`ISC_DW-1:0] rdata_q,
   // lines and requests
   input wire [28:1] periph_irq,
   input wire [`ISC_NEXT-1:0] ext_irq_pin,
   input wire irq_core_q,
   input wire fiq_core_q,
   input wire int_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_fast_vec_zero: assert property (
      rd && addr == `ISC_OFF_FVECTOR |=> rdata_q == `ISC_FAST_VEC)
      else $error("fast vector read not zero");
   a_vec_in_range: assert property (
      rd && addr == `ISC_OFF_VECTOR |=>
      rdata_q != 0 && rdata_q <= `ISC_SPURIOUS)
      else $error("vector index out of range");
   a_mask_enable: assert property (
      wr && addr == `ISC_OFF_ENCMD ##2 rd && addr == `ISC_OFF_MASK |=>
      (rdata_q & $past(wdata, 3)) == $past(wdata, 3))
      else $error("enable command not in mask");
   a_mask_clear_all: assert property (
      wr && addr == `ISC_OFF_DISCMD && wdata == 32'hFFFF_FFFF ##2
      rd && addr == `ISC_OFF_MASK |=> rdata_q == 0)
      else $error("mask not cleared by disable");
   a_req_drop: assert property (
      wr && addr == `ISC_OFF_DISCMD && wdata == 32'hFFFF_FFFF |->
      ##2 !irq_core_q && !fiq_core_q)
      else $error("request stays with all masked");
   a_fforce_bit0: assert property (
      rd && addr == `ISC_OFF_FFORCE |=> !rdata_q[0])
      else $error("fast forcing bit0 set");
   a_mode_width: assert property (
      rd && addr <= `ISC_OFF_MODE_LAST |=> rdata_q[31:2] == 0)
      else $error("mode register upper bits set");
   a_read_pulse: assert property (
      rdata_q != 0 |-> $past(rd))
      else $error("read data without read");
   a_event_mask: assert property (
      wr && addr == `ISC_OFF_EVMSK && wdata == 0 |-> ##2 !int_q)
      else $error("event interrupt despite mask");
endmodule

bind isc_top isc_properties u_props (.clk(clk), .rst_b(rst_b),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
   .periph_irq(periph_irq), .ext_irq_pin(ext_irq_pin),
   .irq_core_q(irq_core_q), .fiq_core_q(fiq_core_q), .int_q(int_q));

/* tb/isc_far.sv */
`timescale 1ns/1ps

// ----------------------------------------
// peripheral lines and external pins
// ----------------------------------------
module isc_far (
   // clock
   input wire clk,
   // lines towards the controller
   output reg [28:1] periph_irq,
   output reg [3:0] ext_irq_pin
);
   // all lines idle low from time zero
   initial begin
      periph_irq = 28'h000_0000;
      ext_irq_pin = 4'h0;
   end

   // move one source line just after an edge
   task drive(input integer src, input reg val);
      @(posedge clk);
      if (src == 0) begin
         ext_irq_pin[0] <= val;
      end else if (src > 28) begin
         ext_irq_pin[src-28] <= val;
      end else begin
         periph_irq[src] <= val;
      end
   endtask
endmodule

/* tb/test_interrupt_source_control.sv */
`timescale 1ns/1ps
`include "isc_defs.vh"

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
   errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module test_interrupt_source_control;
   // ----------------------------------------
   // signals, clock, design and far side
   // ----------------------------------------
   reg clk = 0;
   reg rst_b = 0;
   reg [8:0] addr = 0;
   reg [31:0] wdata = 0;
   reg wr = 0;
   reg rd = 0;
   wire [31:0] rdata_q;
   wire [28:1] periph_irq;
   wire [3:0] ext_irq_pin;
   wire irq_core_q, fiq_core_q, int_q;
   integer errors = 0;
   integer checked = 0;
   localparam [8:0] pend = `ISC_OFF_PENDING;
   localparam [8:0] vec = `ISC_OFF_VECTOR;
   localparam [8:0] msk = `ISC_OFF_MASK;

   always #12.5 clk = ~clk;

   isc_top dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata_q(rdata_q), .periph_irq(periph_irq),
      .ext_irq_pin(ext_irq_pin), .irq_core_q(irq_core_q),
      .fiq_core_q(fiq_core_q), .int_q(int_q));
   isc_far far (.clk(clk), .periph_irq(periph_irq),
      .ext_irq_pin(ext_irq_pin));

   // ----------------------------------------
   // bus tasks and verdict
   // ----------------------------------------
   task finish_test;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task wr_reg(input [8:0] a, input [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      // one idle edge so that back-to-back writes never assign wr twice
      @(posedge clk);
   endtask
   task rd_reg(input [8:0] a, input [31:0] e);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1;
      `CHK(rdata_q, e)
      @(posedge clk);
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      rd_reg(msk, 0);
      rd_reg(`ISC_OFF_FFORCE, 0);
      rd_reg(9'h014, 0);
      rd_reg(pend, 0);
      rd_reg(9'h1F0, 0);
   endtask
   task t_mask;
      integer i;
      wr_reg(`ISC_OFF_ENCMD, 32'h0000_0030);
      rd_reg(msk, 32'h0000_0030);
      wr_reg(`ISC_OFF_DISCMD, 32'h0000_0010);
      rd_reg(msk, 32'h0000_0020);
      wr_reg(`ISC_OFF_EVMSK, 32'h0000_0001);
      far.drive(3, 1);
      far.drive(5, 1);
      for (i = 0; i < 8 && irq_core_q !== 1'b1; i++) @(posedge clk);
      if (i == 8) begin
         errors++;
         finish_test;
      end
      rd_reg(pend, 32'h0000_0028);
      rd_reg(vec, 32'h0000_0005);
      wr_reg(`ISC_OFF_CLRCMD, 32'h0000_0020);
      rd_reg(pend, 32'h0000_0028);
      `CHK(int_q, 1'b1)
      wr_reg(`ISC_OFF_EVMSK, 0);
      tick(2);
      `CHK(int_q, 1'b0)
      wr_reg(`ISC_OFF_EVMSK, 32'h0000_0001);
      wr_reg(`ISC_OFF_EVSTS, 32'h0000_0001);
      tick(2);
      `CHK(int_q, 1'b0)
      far.drive(5, 0);
      tick(3);
      `CHK(irq_core_q, 1'b0)
      far.drive(3, 0);
   endtask
   task t_edge;
      wr_reg(9'h01C, 32'h0000_0002);
      wr_reg(9'h024, 32'h0000_0002);
      rd_reg(9'h01C, 32'h0000_0002);
      wr_reg(`ISC_OFF_SETCMD, 32'h0000_0080);
      rd_reg(pend, 32'h0000_0080);
      wr_reg(`ISC_OFF_CLRCMD, 32'h0000_0080);
      rd_reg(pend, 0);
      far.drive(7, 1);
      far.drive(7, 0);
      far.drive(9, 1);
      tick(3);
      rd_reg(pend, 32'h0000_0280);
      wr_reg(`ISC_OFF_ENCMD, 32'h0000_0280);
      rd_reg(vec, 32'h0000_0007);
      rd_reg(pend, 32'h0000_0200);
      wr_reg(`ISC_OFF_FFORCE, 32'h0000_0200);
      rd_reg(vec, `ISC_SPURIOUS);
      rd_reg(pend, 32'h0000_0200);
      `CHK({fiq_core_q, irq_core_q}, 2'h2)
      rd_reg(`ISC_OFF_EVSTS, 32'h0000_0003);
      wr_reg(`ISC_OFF_EVSTS, 32'h0000_0003);
      wr_reg(`ISC_OFF_CLRCMD, 32'h0000_0200);
      wr_reg(`ISC_OFF_FFORCE, 0);
      far.drive(9, 0);
      wr_reg(`ISC_OFF_DISCMD, 32'hFFFF_FFFF);
      rd_reg(msk, 0);
   endtask
   task t_ext;
      wr_reg(9'h000, 32'h0000_0003);
      wr_reg(9'h074, 32'h0000_0001);
      wr_reg(9'h07C, 32'h0000_0002);
      // switching source 0 to falling inverts its level: drop that edge
      wr_reg(`ISC_OFF_CLRCMD, 32'h0000_0001);
      tick(5);
      rd_reg(pend, 32'h2000_0000);
      far.drive(29, 1);
      far.drive(30, 1);
      far.drive(31, 1);
      tick(5);
      rd_reg(pend, 32'hC000_0000);
      far.drive(30, 0);
      far.drive(31, 0);
      tick(5);
      rd_reg(pend, 32'h8000_0000);
      wr_reg(`ISC_OFF_CLRCMD, 32'h8000_0000);
      far.drive(0, 1);
      tick(5);
      rd_reg(pend, 0);
      far.drive(0, 0);
      tick(5);
      rd_reg(pend, 32'h0000_0001);
      wr_reg(`ISC_OFF_ENCMD, 32'h0000_0001);
      tick(3);
      `CHK(fiq_core_q, 1'b1)
      rd_reg(`ISC_OFF_FVECTOR, 0);
      rd_reg(pend, 0);
   endtask

   // ----------------------------------------
   // main sequence and hang guard
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1;
      t_reset;
      t_mask;
      t_edge;
      t_ext;
      finish_test;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test;
   end
endmodule
